// ==== bench/pst_ctrl_model.sv ====
// far-side controller model: packets, read words, skip fields and exit pin
// assumes a free-running link clock and the sequencer's pause flag
`timescale 1ns/100ps
module pst_ctrl_model (
   // channel clock and device status
   input  wire logic                  linkClock,
   input  wire logic                  pauseActive,
   // toward the device
   output pst_pkg::pst_link_cmd_type  linkCmd,
   output logic [15:0]                readWord,
   output logic                       skipOverrideEnable,
   output logic                       skipManualSelect,
   output logic                       exitReq
);
   int cyc    = 0;
   int enCyc  = -1000;
   int calCyc = -1000;

   initial begin
      linkCmd = '0;
      readWord = 16'hA5C3;
      skipOverrideEnable = 1'b0;
      skipManualSelect = 1'b0;
      exitReq = 1'b0;
   end
   // a new word every cycle so a stale capture cannot match
   always @(negedge linkClock) readWord <= readWord + 16'h3B5D;
   always @(posedge linkClock) cyc <= cyc + 1;

   task automatic send(input logic [6:0] cmd, output logic [15:0] word);
      for (int i = 0; i < 200 && pauseActive; i++) @(negedge linkClock);
      while (cmd[1] && cyc + 1 - enCyc < 150) @(negedge linkClock);
      while (cmd[0] && cyc + 1 - calCyc < 143) @(negedge linkClock);
      @(negedge linkClock);
      linkCmd <= cmd;
      @(negedge linkClock);
      linkCmd <= '0;
      word = readWord;
      if (cmd[2]) enCyc = cyc;
      if (cmd[1]) calCyc = cyc;
      // packet bits stay quiet while the device falls asleep
      if (cmd[4] | cmd[3]) repeat (4) @(negedge linkClock);
   endtask : send

   // link clock never stops and sleep is left well inside its limit
   task automatic wake(input logic level);
      @(negedge linkClock);
      exitReq <= level;
   endtask : wake

   task automatic skip(input logic enable, input logic select);
      @(negedge linkClock);
      skipOverrideEnable <= enable;
      skipManualSelect   <= select;
   endtask : skip
endmodule : pst_ctrl_model

// ==== bench/pst_power_ctrl_assertions.sv ====
// concurrent checks on the power-state sequencer ports
// assumes a bind to the sequencer; link checks wait out the reset sync
`timescale 1ns/100ps
module pst_power_ctrl_assertions #(
   parameter int PAUSE_CYCLES = 20
) (
   // clocks and reset
   input wire logic                       clock,
   input wire logic                       resetn,
   input wire logic                       linkClock,
   // link inputs
   input wire pst_pkg::pst_link_cmd_type  linkCmd,
   input wire logic [pst_pkg::DATA_W-1:0] readWord,
   input wire logic                       skipOverrideEnable,
   input wire logic                       skipManualSelect,
   // outputs
   input wire pst_pkg::pst_power_type     powerState,
   input wire logic                       quietWindow,
   input wire logic                       tempCalArmed,
   input wire pst_pkg::pst_dcw_type       crossWindow,
   input wire logic [pst_pkg::DATA_W-1:0] dqOut,
   input wire logic                       dqOeN,
   input wire logic                       pauseActive,
   input wire logic                       exitBusy
);
   logic [2:0]  linkRst_q = 3'h0;
   logic [7:0]  quietCnt_q;
   logic [15:0] pauseCnt_q;
   logic [15:0] busyCnt_q;

   // link checks start once reset has crossed into the link domain
   always_ff @(posedge linkClock) begin
      linkRst_q  <= {linkRst_q[1:0], resetn};
      quietCnt_q <= quietWindow ? quietCnt_q + 8'h01 : 8'h00;
   end
   always_ff @(posedge clock) begin
      pauseCnt_q <= !resetn ? 16'h0000 : pauseCnt_q + {15'h0000, pauseCnt_q != 16'hFFFF};
      busyCnt_q  <= exitBusy ? busyCnt_q + 16'h0001 : 16'h0000;
   end

   AST_STANDBY_STATE_TO_ATTENTION_STATE: assert property (@(posedge linkClock) disable iff (!linkRst_q[2])
      linkCmd.attnPkt && $past(powerState) == pst_pkg::PS_STANDBY
      |-> (powerState == pst_pkg::PS_ATTENTION) [*2]) else $error("late attention");
   AST_ATTENTION_STATE_TO_STANDBY_STATE: assert property (@(posedge linkClock) disable iff (!linkRst_q[2])
      linkCmd.idle && powerState == pst_pkg::PS_ATTENTION
      |=> powerState == pst_pkg::PS_STANDBY) else $error("late standby");
   AST_LIGHT_ENTRY: assert property (@(posedge linkClock) disable iff (!linkRst_q[2])
      linkCmd.lightSleepCmd && !powerState[1]
      |=> !powerState[1] [*7] ##1 powerState == pst_pkg::PS_LIGHT_SLEEP) else $error("light");
   AST_DEEP_ENTRY: assert property (@(posedge linkClock) disable iff (!linkRst_q[2])
      linkCmd.deepSleepCmd && !powerState[1]
      |=> !powerState[1] [*7] ##1 powerState == pst_pkg::PS_DEEP_SLEEP) else $error("deep");
   AST_PS_LEGAL: assert property (@(posedge linkClock) disable iff (!linkRst_q[2])
      $changed(powerState) |-> powerState == pst_pkg::PS_STANDBY
      || $past(powerState) inside {pst_pkg::PS_ATTENTION, pst_pkg::PS_STANDBY})
      else $error("illegal power step");
   AST_QUIET_START: assert property (@(posedge linkClock) disable iff (!linkRst_q[2])
      linkCmd.tempCalCmd && tempCalArmed |=> !quietWindow ##1 quietWindow)
      else $error("quiet start");
   AST_QUIET_LEN: assert property (@(posedge linkClock) disable iff (!linkRst_q[2])
      $fell(quietWindow) |-> quietCnt_q == 8'h8C) else $error("quiet length");
   AST_QUIET_NO_DATA: assert property (@(posedge linkClock) disable iff (!linkRst_q[2])
      quietWindow |=> dqOeN) else $error("data in quiet window");
   AST_READ_DATA: assert property (@(posedge linkClock) disable iff (!linkRst_q[2])
      linkCmd.readReq && powerState == pst_pkg::PS_ATTENTION && !quietWindow
      |=> !dqOeN && dqOut == $past(readWord)) else $error("read data");
   AST_SKIP: assert property (@(posedge linkClock) disable iff (!linkRst_q[2])
      $stable({skipOverrideEnable, skipManualSelect}) |-> crossWindow ==
      ((skipOverrideEnable && skipManualSelect) ? 8'h00
      : {pst_pkg::DCW_TENTHS, pst_pkg::DCW_TENTHS})) else $error("crossing window");
   AST_PAUSE_HOLD: assert property (@(posedge clock) disable iff (!resetn)
      pauseCnt_q < 16'(PAUSE_CYCLES) |-> pauseActive) else $error("pause too short");
   AST_PAUSE_END: assert property (@(posedge clock) disable iff (!resetn)
      pauseCnt_q > 16'(PAUSE_CYCLES + 3) |-> !pauseActive) else $error("pause too long");
   AST_EXIT_BOUND: assert property (@(posedge clock) disable iff (!resetn)
      exitBusy |-> busyCnt_q < 16'(pst_pkg::DEEP_EXIT_A_CYC)) else $error("exit too long");

   cover property (@(posedge linkClock) $rose(quietWindow));
   cover property (@(posedge linkClock) powerState == pst_pkg::PS_LIGHT_SLEEP);
   cover property (@(posedge linkClock) powerState == pst_pkg::PS_DEEP_SLEEP);
endmodule : pst_power_ctrl_assertions

// ==== bench/testbench.sv ====
// self-checking bench for the power-state sequencer
// assumes the controller model drives the link side
`timescale 1ns/100ps
module testbench;
   localparam int PAUSE  = 20;
   localparam int DEEP_B = 5;
   logic                      clock = 1'b0;
   logic                      linkClock = 1'b0;
   logic                      resetn = 1'b0;
   logic                      exitReq;
   logic                      skipOverrideEnable;
   logic                      skipManualSelect;
   logic                      quietWindow;
   logic                      tempCalArmed;
   logic                      dqOeN;
   logic                      pauseActive;
   logic                      exitBusy;
   logic [15:0]               readWord;
   logic [15:0]               dqOut;
   logic [15:0]               word;
   pst_pkg::pst_link_cmd_type linkCmd;
   pst_pkg::pst_power_type    powerState;
   pst_pkg::pst_dcw_type      crossWindow;
   int                        error_cnt = 0;
   int                        cmp_count = 0;

   always #2 clock = ~clock;
   initial begin
      #1.3;
      forever #6 linkClock = ~linkClock;
   end

   pst_power_ctrl #(.PAUSE_CYCLES(PAUSE), .DEEP_EXIT_B_CYCLES(DEEP_B)) pst_power_ctrl_i (
      .clock, .resetn, .linkClock, .linkCmd, .readWord, .skipOverrideEnable,
      .skipManualSelect, .exitReq, .powerState, .quietWindow, .tempCalArmed, .crossWindow,
      .dqOut, .dqOeN, .pauseActive, .exitBusy);
   pst_ctrl_model pst_ctrl_model_i (
      .linkClock, .pauseActive, .linkCmd, .readWord, .skipOverrideEnable,
      .skipManualSelect, .exitReq);

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic conclude;
      $display("comparisons %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude

   task automatic give_up;
      $display("ERROR %0t wait limit reached", $time);
      error_cnt++;
      conclude();
   endtask : give_up

   task automatic t_reset;
      int n;
      repeat (16) @(negedge clock);
      chk(16'(powerState), 16'h0001);
      chk(16'(quietWindow | tempCalArmed | !dqOeN), 16'h0000);
      chk(16'(crossWindow), 16'h0011);
      chk(dqOut, 16'h0000);
      resetn = 1'b1;
      n = 0;
      while (pauseActive !== 1'b0 && n < 200) begin
         @(negedge clock);
         n++;
      end
      if (n >= 200) give_up();
      chk(16'(n >= PAUSE && n <= PAUSE + 2), 16'h0001);
   endtask : t_reset

   task automatic t_attention_state;
      pst_ctrl_model_i.send(7'h40, word);
      chk(16'(powerState), 16'h0000);
      pst_ctrl_model_i.send(7'h01, word);
      chk({dqOut[14:0], dqOeN}, {word[14:0], 1'b0});
      pst_ctrl_model_i.send(7'h20, word);
      chk(16'(powerState), 16'h0001);
      pst_ctrl_model_i.send(7'h01, word);
      chk({dqOut[15:1], dqOeN}, 16'h0001);
   endtask : t_attention_state

   task automatic t_skip;
      for (int i = 0; i < 4; i++) begin
         pst_ctrl_model_i.skip(i[1], i[0]);
         repeat (3) @(negedge linkClock);
         chk(16'(crossWindow), (i == 3) ? 16'h0000 : 16'h0011);
      end
   endtask : t_skip

   task automatic t_cal;
      int n;
      pst_ctrl_model_i.send(7'h02, word);
      repeat (2) @(negedge linkClock);
      chk(16'(quietWindow), 16'h0000);
      pst_ctrl_model_i.send(7'h04, word);
      chk(16'(tempCalArmed), 16'h0001);
      pst_ctrl_model_i.send(7'h02, word);
      chk(16'(quietWindow), 16'h0000);
      @(negedge linkClock);
      chk(16'(quietWindow), 16'h0001);
      n = 1;
      while (quietWindow && n < 300) begin
         @(negedge linkClock);
         n += quietWindow;
      end
      chk(16'(n), 16'h008C);
   endtask : t_cal

   task automatic t_sleep(input logic deep);
      int n, busy, after;
      pst_pkg::pst_power_type target;
      target = deep ? pst_pkg::PS_DEEP_SLEEP : pst_pkg::PS_LIGHT_SLEEP;
      if (deep) pst_ctrl_model_i.send(7'h40, word);
      pst_ctrl_model_i.send(deep ? 7'h08 : 7'h10, word);
      n = 5;
      while (powerState !== target && n < 20) begin
         @(negedge linkClock);
         n++;
      end
      chk(16'(n), 16'h0008);
      repeat (10) @(negedge clock);
      pst_ctrl_model_i.wake(1'b1);
      busy = 0;
      after = 0;
      n = 0;
      while (powerState !== pst_pkg::PS_STANDBY && n < 2000) begin
         @(negedge clock);
         n++;
         busy += exitBusy;
         after += (!exitBusy && busy > 0);
      end
      if (n >= 2000) give_up();
      chk(16'(busy > 0 && busy <= (deep ? pst_pkg::DEEP_EXIT_A_CYC
         : pst_pkg::LIGHT_EXIT_A_CYC + pst_pkg::LIGHT_EXIT_B_CYC)), 16'h0001);
      chk(16'(after <= ((deep ? DEEP_B : 0) + 6) * 3), 16'h0001);
      pst_ctrl_model_i.wake(1'b0);
   endtask : t_sleep

   initial begin
      t_reset();
      t_attention_state();
      t_skip();
      t_cal();
      t_sleep(1'b0);
      t_sleep(1'b1);
      conclude();
   end
endmodule : testbench

bind pst_power_ctrl pst_power_ctrl_assertions #(.PAUSE_CYCLES(PAUSE_CYCLES)) chk_i (
   .clock, .resetn, .linkClock, .linkCmd, .readWord, .skipOverrideEnable,
   .skipManualSelect, .powerState, .quietWindow, .tempCalArmed, .crossWindow,
   .dqOut, .dqOeN, .pauseActive, .exitBusy);

// ==== logic/pst_pkg.sv ====
// power-state and temperature-calibration timing constants and types
// assumes a 250 MHz core clock and channel-clock counts on the link side
package pst_pkg;

   // core clock period
   localparam int CORE_PERIOD_NS = 4;

   // light-sleep exit, both phases are longest times: round down
   localparam int LIGHT_EXIT_A_NS  = 50;
   localparam int LIGHT_EXIT_B_NS  = 40;
   localparam int LIGHT_EXIT_A_CYC = LIGHT_EXIT_A_NS / CORE_PERIOD_NS;
   localparam int LIGHT_EXIT_B_CYC = LIGHT_EXIT_B_NS / CORE_PERIOD_NS;

   // deep-sleep exit, phase a in time, phase b in channel cycles
   localparam int DEEP_EXIT_A_US  = 4;
   localparam int DEEP_EXIT_A_CYC = DEEP_EXIT_A_US * 1000 / CORE_PERIOD_NS;
   localparam int DEEP_EXIT_B_CYC = 9000;

   // internal pause after reset, no channel operations meanwhile
   localparam real PAUSE_US  = 200.0;
   localparam int  PAUSE_CYC = $rtoi(PAUSE_US * 1000.0 / CORE_PERIOD_NS);

   // power-state delays in channel cycles
   localparam int ATTENTION_STATE_TO_STANDBY_STATE_CYC = 1;
   localparam int STANDBY_STATE_TO_ATTENTION_STATE_CYC = 0;
   localparam int SLEEP_ENTRY_CYC  = 8;

   // temperature calibration in channel cycles
   localparam int TEMP_CAL_CMD_ENABLE_MIN_CYC = 150;
   localparam int TEMP_CAL_CMD_DELAY_CYC      = 2;
   localparam int TEMP_CAL_CMD_QUIET_CYC      = 140;

   // domain-crossing window, tenths of a channel cycle per side
   localparam logic [3:0] DCW_TENTHS      = 4'h1;
   localparam logic [3:0] DCW_TENTHS_SKIP = 4'h0;

   localparam int TIMER_W = 16;
   localparam int DATA_W  = 16;

   typedef enum logic [1:0] {
      PS_ATTENTION   = 2'h0,
      PS_STANDBY     = 2'h1,
      PS_LIGHT_SLEEP = 2'h2,
      PS_DEEP_SLEEP  = 2'h3
   } pst_power_type;

   typedef enum logic [2:0] {
      LK_ATTENTION = 3'h0,
      LK_STANDBY   = 3'h1,
      LK_ENTERING  = 3'h3,
      LK_SLEEPING  = 3'h2,
      LK_WAKING    = 3'h6
   } pst_link_state_type;

   typedef enum logic [1:0] {
      CR_AWAKE  = 2'h0,
      CR_ASLEEP = 2'h1,
      CR_PHASEA = 2'h3,
      CR_PHASEB = 2'h2
   } pst_core_state_type;

   // decoded packet events, one-cycle pulses on the channel clock
   typedef struct packed {
      logic attnPkt;
      logic idle;
      logic lightSleepCmd;
      logic deepSleepCmd;
      logic tempCalEnableCmd;
      logic tempCalCmd;
      logic readReq;
   } pst_link_cmd_type;

   typedef struct packed {
      logic [3:0] early;
      logic [3:0] late;
   } pst_dcw_type;

endpackage : pst_pkg

// ==== logic/pst_power_ctrl.sv ====
// power-state and temperature-calibration sequencer of a packet-channel memory
// assumes packet decode upstream on linkClock; exitReq is an async pin
//
// Overview of operation
// - quiet window starts 2 cycles after calibrate
// - light-sleep exit phase a within 50 ns
// - light-sleep exit phase b within 40 ns
// - deep-sleep exit phase a within 4 us
// - deep-sleep exit phase b within 9000 cycles
// - attention to standby within 1 cycle
// - standby to attention with no delay
// - light-sleep reached within 8 cycles of command
// - deep-sleep reached within 8 cycles of command
// - both skip fields set zero the window
`timescale 1ns/100ps
module pst_power_ctrl #(
   parameter int PAUSE_CYCLES      = pst_pkg::PAUSE_CYC,
   parameter int DEEP_EXIT_B_CYCLES = pst_pkg::DEEP_EXIT_B_CYC
) (
   // core clock and reset
   input  wire logic                       clock,
   input  wire logic                       resetn,
   // channel clock
   input  wire logic                       linkClock,
   // decoded channel packets
   input  wire pst_pkg::pst_link_cmd_type  linkCmd,
   input  wire logic [pst_pkg::DATA_W-1:0] readWord,
   // skip override fields, levels on linkClock
   input  wire logic                       skipOverrideEnable,
   input  wire logic                       skipManualSelect,
   // sleep exit request pin
   input  wire logic                       exitReq,
   // channel status
   output pst_pkg::pst_power_type          powerState,
   output logic                            quietWindow,
   output logic                            tempCalArmed,
   output pst_pkg::pst_dcw_type            crossWindow,
   // read data pins
   output logic [pst_pkg::DATA_W-1:0]      dqOut,
   output logic                            dqOeN,
   // core status
   output logic                            pauseActive,
   output logic                            exitBusy
);

   localparam logic [pst_pkg::TIMER_W-1:0] PAUSE_LOAD  = pst_pkg::TIMER_W'(PAUSE_CYCLES);
   localparam logic [pst_pkg::TIMER_W-1:0] LA_LOAD     =
      pst_pkg::TIMER_W'(pst_pkg::LIGHT_EXIT_A_CYC);
   localparam logic [pst_pkg::TIMER_W-1:0] LB_LOAD     =
      pst_pkg::TIMER_W'(pst_pkg::LIGHT_EXIT_B_CYC);
   localparam logic [pst_pkg::TIMER_W-1:0] DA_LOAD     =
      pst_pkg::TIMER_W'(pst_pkg::DEEP_EXIT_A_CYC);
   localparam logic [pst_pkg::TIMER_W-1:0] DB_LOAD     =
      pst_pkg::TIMER_W'(DEEP_EXIT_B_CYCLES);
   // entry counter reloads so the new state shows in the eighth cycle
   localparam logic [3:0] ENTRY_LOAD = 4'(pst_pkg::SLEEP_ENTRY_CYC - 2);
   localparam logic [1:0] CAL_LOAD   = 2'(pst_pkg::TEMP_CAL_CMD_DELAY_CYC - 1);
   localparam logic [7:0] QUIET_LOAD = 8'(pst_pkg::TEMP_CAL_CMD_QUIET_CYC - 1);

   // ---------------------------------------------------------------
   // core clock domain
   // ---------------------------------------------------------------
   typedef struct packed {
      pst_pkg::pst_core_state_type st;
      logic                        deep;
      logic                        sleepSeen;
      logic                        exitSeen;
      logic                        wakeTgl;
      logic                        pauseStarted;
      logic                        pauseBusy;
   } pst_core_regs_type;

   pst_core_regs_type            core_q;
   pst_core_regs_type            core_d;
   logic                         exitSync;
   logic                         sleepSync;
   logic                         deepSync;
   logic                         pauseLoad;
   logic                         pauseDone;
   logic                         exitLoad;
   logic [pst_pkg::TIMER_W-1:0]  exitLoadValue;
   logic                         exitDone;
   logic                         exitTimerBusy;

   // ---------------------------------------------------------------
   // link clock domain
   // ---------------------------------------------------------------
   typedef struct packed {
      pst_pkg::pst_link_state_type st;
      pst_pkg::pst_power_type      ps;
      logic                        deep;
      logic [3:0]                  entryCnt;
      logic                        sleepTgl;
      logic                        wakeSeen;
      logic                        calArmed;
      logic [1:0]                  calDelay;
      logic                        quiet;
      logic [7:0]                  quietCnt;
      logic                        dqDrive;
      logic [pst_pkg::DATA_W-1:0]  dqWord;
      pst_pkg::pst_dcw_type        dcw;
   } pst_link_regs_type;

   pst_link_regs_type            link_q;
   pst_link_regs_type            link_d;
   logic                         linkResetn;
   logic                         wakeSync;
   logic                         wakeLoad;
   logic                         wakeDone;
   logic                         attnNow;

   // ---------------------------------------------------------------
   // crossings
   // ---------------------------------------------------------------
   pst_sync #(.W(1)) u_exit_sync (
      .clock   (clock),
      .asyncIn (exitReq),
      .syncOut (exitSync)
   );

   pst_sync #(.W(2)) u_sleep_sync (
      .clock   (clock),
      .asyncIn ({link_q.sleepTgl, link_q.deep}),
      .syncOut ({sleepSync, deepSync})
   );

   pst_sync #(.W(2)) u_link_sync (
      .clock   (linkClock),
      .asyncIn ({resetn, core_q.wakeTgl}),
      .syncOut ({linkResetn, wakeSync})
   );

   // ---------------------------------------------------------------
   // core timers
   // ---------------------------------------------------------------
   pst_timer u_pause_timer (
      .clock     (clock),
      .resetn    (resetn),
      .load      (pauseLoad),
      .loadValue (PAUSE_LOAD),
      .busy      (),
      .expire    (pauseDone)
   );

   pst_timer u_exit_timer (
      .clock     (clock),
      .resetn    (resetn),
      .load      (exitLoad),
      .loadValue (exitLoadValue),
      .busy      (exitTimerBusy),
      .expire    (exitDone)
   );

   always_comb begin
      core_d        = core_q;
      pauseLoad     = 1'b0;
      exitLoad      = 1'b0;
      exitLoadValue = '0;
      core_d.sleepSeen = sleepSync;
      core_d.exitSeen  = exitSync;
      // internal pause runs once from reset release
      if (!core_q.pauseStarted) begin
         pauseLoad           = 1'b1;
         core_d.pauseStarted = 1'b1;
      end
      if (pauseDone) begin
         core_d.pauseBusy = 1'b0;
      end
      unique case (core_q.st)
         pst_pkg::CR_AWAKE: begin
            if (sleepSync != core_q.sleepSeen) begin
               core_d.st = pst_pkg::CR_ASLEEP;
            end
         end
         pst_pkg::CR_ASLEEP: begin
            if (exitSync && !core_q.exitSeen) begin
               core_d.st     = pst_pkg::CR_PHASEA;
               core_d.deep   = deepSync;
               exitLoad      = 1'b1;
               exitLoadValue = deepSync ? DA_LOAD : LA_LOAD;
            end
         end
         pst_pkg::CR_PHASEA: begin
            if (exitDone) begin
               if (core_q.deep) begin
                  // phase b of deep exit is counted on the channel clock
                  core_d.wakeTgl = ~core_q.wakeTgl;
                  core_d.st      = pst_pkg::CR_AWAKE;
               end else begin
                  exitLoad      = 1'b1;
                  exitLoadValue = LB_LOAD;
                  core_d.st     = pst_pkg::CR_PHASEB;
               end
            end
         end
         pst_pkg::CR_PHASEB: begin
            if (exitDone) begin
               core_d.wakeTgl = ~core_q.wakeTgl;
               core_d.st      = pst_pkg::CR_AWAKE;
            end
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         core_q <= '{st: pst_pkg::CR_AWAKE, pauseBusy: 1'b1, default: '0};
      end else begin
         core_q <= core_d;
      end
   end

   assign pauseActive = core_q.pauseBusy;
   assign exitBusy    = exitTimerBusy;

   // ---------------------------------------------------------------
   // link logic
   // ---------------------------------------------------------------
   pst_timer u_wake_timer (
      .clock     (linkClock),
      .resetn    (linkResetn),
      .load      (wakeLoad),
      .loadValue (DB_LOAD),
      .busy      (),
      .expire    (wakeDone)
   );

   // standby answers an attention packet in the same cycle
   assign attnNow = (link_q.st == pst_pkg::LK_STANDBY) && linkCmd.attnPkt;

   always_comb begin
      link_d          = link_q;
      wakeLoad        = 1'b0;
      link_d.wakeSeen = wakeSync;
      unique case (link_q.st)
         pst_pkg::LK_ATTENTION, pst_pkg::LK_STANDBY: begin
            if (linkCmd.lightSleepCmd || linkCmd.deepSleepCmd) begin
               link_d.st       = pst_pkg::LK_ENTERING;
               link_d.deep     = linkCmd.deepSleepCmd;
               link_d.entryCnt = ENTRY_LOAD;
            end else if (attnNow) begin
               link_d.st = pst_pkg::LK_ATTENTION;
               link_d.ps = pst_pkg::PS_ATTENTION;
            end else if ((link_q.st == pst_pkg::LK_ATTENTION) && linkCmd.idle) begin
               link_d.st = pst_pkg::LK_STANDBY;
               link_d.ps = pst_pkg::PS_STANDBY;
            end
         end
         pst_pkg::LK_ENTERING: begin
            if (link_q.entryCnt == '0) begin
               link_d.st       = pst_pkg::LK_SLEEPING;
               link_d.ps       = link_q.deep ? pst_pkg::PS_DEEP_SLEEP
                                             : pst_pkg::PS_LIGHT_SLEEP;
               link_d.sleepTgl = ~link_q.sleepTgl;
            end else begin
               link_d.entryCnt = link_q.entryCnt - 1'b1;
            end
         end
         pst_pkg::LK_SLEEPING: begin
            // channel clocks are running again before the wake toggle lands
            if (wakeSync != link_q.wakeSeen) begin
               if (link_q.deep) begin
                  wakeLoad  = 1'b1;
                  link_d.st = pst_pkg::LK_WAKING;
               end else begin
                  link_d.st = pst_pkg::LK_STANDBY;
                  link_d.ps = pst_pkg::PS_STANDBY;
               end
            end
         end
         pst_pkg::LK_WAKING: begin
            if (wakeDone) begin
               link_d.st = pst_pkg::LK_STANDBY;
               link_d.ps = pst_pkg::PS_STANDBY;
            end
         end
         default: begin
            link_d.st = pst_pkg::LK_STANDBY;
            link_d.ps = pst_pkg::PS_STANDBY;
         end
      endcase

      // temperature calibration: window end first so a new start wins
      if (link_q.quiet) begin
         if (link_q.quietCnt == '0) begin
            link_d.quiet = 1'b0;
         end else begin
            link_d.quietCnt = link_q.quietCnt - 1'b1;
         end
      end
      if (link_q.calDelay != '0) begin
         link_d.calDelay = link_q.calDelay - 1'b1;
         if (link_q.calDelay == 2'h1) begin
            link_d.quiet    = 1'b1;
            link_d.quietCnt = QUIET_LOAD;
         end
      end
      if (linkCmd.tempCalCmd && link_q.calArmed) begin
         link_d.calArmed = 1'b0;
         link_d.calDelay = CAL_LOAD;
      end
      if (linkCmd.tempCalEnableCmd) begin
         link_d.calArmed = 1'b1;
      end

      // read data only in attention and outside the quiet window
      link_d.dqDrive = linkCmd.readReq && !link_d.quiet &&
                       (link_d.ps == pst_pkg::PS_ATTENTION);
      link_d.dqWord  = link_d.dqDrive ? readWord : '0;

      // skip override collapses the crossing window on both sides
      if (skipOverrideEnable && skipManualSelect) begin
         link_d.dcw = '{early: pst_pkg::DCW_TENTHS_SKIP,
                        late:  pst_pkg::DCW_TENTHS_SKIP};
      end else begin
         link_d.dcw = '{early: pst_pkg::DCW_TENTHS, late: pst_pkg::DCW_TENTHS};
      end
   end

   always_ff @(posedge linkClock) begin
      if (!linkResetn) begin
         link_q <= '{st: pst_pkg::LK_STANDBY, ps: pst_pkg::PS_STANDBY,
                     dcw: '{early: pst_pkg::DCW_TENTHS, late: pst_pkg::DCW_TENTHS},
                     default: '0};
      end else begin
         link_q <= link_d;
      end
   end

   assign powerState   = attnNow ? pst_pkg::PS_ATTENTION : link_q.ps;
   assign quietWindow  = link_q.quiet;
   assign tempCalArmed = link_q.calArmed;
   assign crossWindow  = link_q.dcw;
   assign dqOut        = link_q.dqWord;
   assign dqOeN        = ~link_q.dqDrive;

endmodule : pst_power_ctrl

// ==== logic/pst_sync.sv ====
// two-flop level synchroniser, one bit per lane
// assumes inputs are levels that hold for more than two destination clocks
`timescale 1ns/100ps
module pst_sync #(
   parameter int W = 1
) (
   // destination clock
   input  wire logic         clock,
   // asynchronous levels in, synchronised levels out
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge clock) begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
   end

   assign syncOut = sync_q;

endmodule : pst_sync

// ==== logic/pst_timer.sv ====
// loadable down-counter; expire pulses in the last counted cycle
// assumes loadValue is at least one when load is high
`timescale 1ns/100ps
module pst_timer (
   // clock and synchronous reset
   input  wire logic                        clock,
   input  wire logic                        resetn,
   // control
   input  wire logic                        load,
   input  wire logic [pst_pkg::TIMER_W-1:0] loadValue,
   // status
   output logic                             busy,
   output logic                             expire
);
   logic [pst_pkg::TIMER_W-1:0] count_q;
   logic [pst_pkg::TIMER_W-1:0] count_d;

   always_comb begin
      count_d = count_q;
      if (load) begin
         count_d = loadValue;
      end else if (count_q != '0) begin
         count_d = count_q - 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end

   assign busy   = (count_q != '0);
   assign expire = (count_q == pst_pkg::TIMER_W'(1));

endmodule : pst_timer
